// ===== dv/abe_exec_bench.sv
// Self-checking bench for the add/and/bit execute block
`timescale 1ns/1ns
`default_nettype none
module abe_exec_bench;
  import abe_pkg::*;
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, psc = 1'b0;
  logic [INSTR_W-1:0] ins = '0;
  logic [DATA_W-1:0]  pins = 8'ha6;
  logic [DATA_W-1:0]  rdata, wdata, acc, e_acc, r, t, v;
  logic [ADDR_W-1:0]  addr;
  logic ready, rd, we, cy, dcy, zf, clr, done, skip, nop, e_c, e_dc, e_z;
  int bad_count = 0, cmp_count = 0;

  always #50 clk = ~clk;

  abe_exec u_dut (.I_CLK(clk), .I_RST(rst), .I_INSTR_VALID(vld), .I_INSTR(ins),
    .I_FILE_RDATA(rdata), .I_PORT_PINS(pins), .I_PRESCALER_ON_TIMER0(psc),
    .O_READY(ready), .O_FILE_ADDR(addr), .O_FILE_RD(rd), .O_FILE_WE(we),
    .O_FILE_WDATA(wdata), .O_ACC(acc), .O_CARRY(cy), .O_DIGIT_CARRY(dcy), .O_ZERO(zf),
    .O_PRESCALER_CLR(clr), .O_DONE(done), .O_SKIP_NEXT(skip), .O_NOP_CYCLE(nop));

  abe_file_model u_model (.i_clk(clk), .i_addr(addr), .i_rd(rd), .i_we(we),
    .i_wdata(wdata), .o_rdata(rdata));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask

  // Expected sum; flags follow the full result even when it lands in the file
  function automatic logic [7:0] add_f(input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, e_acc} + {1'b0, b};
    e_dc = ({1'b0, e_acc[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
    e_c = s[8];
    e_z = (s[7:0] == 8'h00);
    return s[7:0];
  endfunction

  // Expected AND; carry and digit carry are left alone
  function automatic logic [7:0] and_f(input logic [7:0] b);
    e_z = ((e_acc & b) == 8'h00);
    return e_acc & b;
  endfunction

  // Offer one instruction at a falling edge and check the execute cycle outcome
  task automatic run(input logic [13:0] w, input logic e_we, input logic [7:0] e_wd,
                     input logic two, input logic e_clr);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    vld = 1'b1;
    ins = w;
    @(negedge clk);
    vld = 1'b0;
    check1(rd, w[13:12] != LIT_CLASS);
    check8({1'b0, addr}, {1'b0, w[6:0]});
    @(negedge clk);
    check1(done, 1'b1);
    check1(rd, 1'b0);
    check1(we, e_we);
    if (e_we) check8(wdata, e_wd);
    check1(skip, two);
    check1(nop, two);
    check1(ready, ~two);
    check1(clr, e_clr);
    check8(acc, e_acc);
    check1(cy, e_c);
    check1(dcy, e_dc);
    check1(zf, e_z);
    if (two) begin
      @(negedge clk);
      check1(ready, 1'b1);
      check1(done, 1'b0);
    end
  endtask

  initial begin
    {e_acc, e_c, e_dc, e_z} = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    u_model.mem[7'h20] = 8'hc8;
    u_model.mem[7'h21] = 8'h05;
    u_model.mem[7'h22] = 8'h3f;
    u_model.mem[7'h30] = 8'h00;
    u_model.mem[PORT_ADDR] = 8'hff;
    u_model.mem[TIMER0_COUNT_ADDR] = 8'h10;
    u_model.mem[7'h40] = 8'h5a;
    u_model.mem[PC_LOW_ADDR] = 8'h00;
    e_acc = and_f(8'h00); run({OPC_AND_LIT, 8'h00}, 1'b0, 8'h00, 1'b0, 1'b0);
    e_acc = add_f(8'hff); run({OPC_ADD_LIT, 1'b0, 8'hff}, 1'b0, 8'h00, 1'b0, 1'b0);
    e_acc = add_f(8'h01); run({OPC_ADD_LIT, 1'b0, 8'h01}, 1'b0, 8'h00, 1'b0, 1'b0);
    e_acc = add_f(8'h38); run({OPC_ADD_LIT, 1'b0, 8'h38}, 1'b0, 8'h00, 1'b0, 1'b0);
    e_acc = add_f(8'hc8); run({OPC_ADD_FILE, 1'b0, 7'h20}, 1'b0, 8'h00, 1'b0, 1'b0);
    e_acc = add_f(8'h3c); run({OPC_ADD_LIT, 1'b0, 8'h3c}, 1'b0, 8'h00, 1'b0, 1'b0);
    r = add_f(8'h05); run({OPC_ADD_FILE, 1'b1, 7'h21}, 1'b1, r, 1'b0, 1'b0);
    e_acc = and_f(r); run({OPC_AND_FILE, 1'b0, 7'h21}, 1'b0, 8'h00, 1'b0, 1'b0);
    e_acc = add_f(8'hf0); run({OPC_ADD_LIT, 1'b0, 8'hf0}, 1'b0, 8'h00, 1'b0, 1'b0);
    e_acc = add_f(8'h20); run({OPC_ADD_LIT, 1'b0, 8'h20}, 1'b0, 8'h00, 1'b0, 1'b0);
    r = and_f(8'h3f); run({OPC_AND_FILE, 1'b1, 7'h22}, 1'b1, r, 1'b0, 1'b0);
    e_acc = and_f(8'h0f); run({OPC_AND_LIT, 8'h0f}, 1'b0, 8'h00, 1'b0, 1'b0);
    // Walk every bit position low to high setting, then low to high clearing, flags must hold
    v = 8'h00;
    for (int b = 0; b < 8; b++) begin
      v[b] = 1'b1;
      run({OPC_BIT_SET, 3'(b), 7'h30}, 1'b1, v, 1'b0, 1'b0);
    end
    for (int b = 0; b < 8; b++) begin
      v[b] = 1'b0;
      run({OPC_BIT_CLR, 3'(b), 7'h30}, 1'b1, v, 1'b0, 1'b0);
    end
    // Port latch holds all ones; pins must be the source
    run({OPC_BIT_SET, 3'd0, PORT_ADDR}, 1'b1, 8'ha7, 1'b0, 1'b0);
    e_acc = add_f(8'ha6); run({OPC_ADD_FILE, 1'b0, PORT_ADDR}, 1'b0, 8'h00, 1'b0, 1'b0);
    // Timer0 writes with prescaler on and off, and a read-only destination
    psc = 1'b1;
    r = add_f(8'h10); run({OPC_ADD_FILE, 1'b1, TIMER0_COUNT_ADDR}, 1'b1, r, 1'b0, 1'b1);
    t = r;
    psc = 1'b0;
    r = add_f(t); run({OPC_ADD_FILE, 1'b1, TIMER0_COUNT_ADDR}, 1'b1, r, 1'b0, 1'b0);
    t = r;
    psc = 1'b1;
    e_acc = and_f(t); run({OPC_AND_FILE, 1'b0, TIMER0_COUNT_ADDR}, 1'b0, 8'h00, 1'b0, 1'b0);
    run({OPC_BIT_SET, 3'd7, TIMER0_COUNT_ADDR}, 1'b1, t | 8'h80, 1'b0, 1'b1);
    // Every bit of a mixed pattern through both test-and-skip forms
    for (int b = 0; b < 8; b++) begin
      run({OPC_TEST_CLR, 3'(b), 7'h40}, 1'b0, 8'h00, ~u_model.mem[7'h40][b], 1'b0);
      run({OPC_TEST_SET, 3'(b), 7'h40}, 1'b0, 8'h00, u_model.mem[7'h40][b], 1'b0);
    end
    // Low program counter byte written costs a no-op cycle; read only does not
    r = add_f(8'h00); run({OPC_ADD_FILE, 1'b1, PC_LOW_ADDR}, 1'b1, r, 1'b1, 1'b0);
    e_acc = add_f(r); run({OPC_ADD_FILE, 1'b0, PC_LOW_ADDR}, 1'b0, 8'h00, 1'b0, 1'b0);
    // Don't-care bit of add literal set, then a mid-run reset must clear sum, carry and digit carry
    e_acc = add_f(8'hf9); run({OPC_ADD_LIT, 1'b1, 8'hf9}, 1'b0, 8'h00, 1'b0, 1'b0);
    rst = 1'b1;
    @(negedge clk);
    check8(acc, ACC_RST);
    check1(cy, FLAG_RST);
    check1(dcy, FLAG_RST);
    check1(ready, 1'b1);
    check1(done, 1'b0);
    rst = 1'b0;
    // A word outside this block's set runs as a one-cycle no-op
    {e_acc, e_c, e_dc, e_z} = '0;
    run(14'h0040, 1'b0, 8'h00, 1'b0, 1'b0);
    check8(u_model.mem[7'h21], 8'h41);
    end_sim;
  end

  // Whole sequence needs well under 500 cycles
  initial begin
    #200000;
    bad_count++;
    $display("unexpected at %0t: sequence did not finish", $time);
    end_sim;
  end
endmodule
`default_nettype wire

// ===== dv/abe_file_model.sv
// Behavioural data register file facing the execute block
`timescale 1ns/1ns
`default_nettype none
module abe_file_model (
  input  wire logic                        i_clk,
  input  wire logic [abe_pkg::ADDR_W-1:0] i_addr,
  input  wire logic                        i_rd,
  input  wire logic                        i_we,
  input  wire logic [abe_pkg::DATA_W-1:0] i_wdata,
  output logic      [abe_pkg::DATA_W-1:0] o_rdata
);
  import abe_pkg::*;
  logic [DATA_W-1:0] mem [0:127];
  logic [DATA_W-1:0] last_q;

  // Outside a read the bus shows the inverse of the last value, so stale data never passes
  assign o_rdata = i_rd ? mem[i_addr] : ~last_q;

  // Write port and read history; plain always so the bench may preload
  always @(posedge i_clk) begin
    if (i_rd) last_q <= mem[i_addr];
    if (i_we) mem[i_addr] <= i_wdata;
  end
endmodule
`default_nettype wire

// ===== logic/abe_alu.sv
// Combinational decode and arithmetic for the add/and/bit instructions
`timescale 1ns/1ns
`default_nettype none
module abe_alu (
  input  wire logic [abe_pkg::INSTR_W-1:0] i_instr,
  input  wire logic [abe_pkg::DATA_W-1:0]  i_acc,
  input  wire logic [abe_pkg::DATA_W-1:0]  i_oper,
  input  wire logic                        i_c,
  input  wire logic                        i_dc,
  input  wire logic                        i_z,
  output logic      [abe_pkg::DATA_W-1:0]  o_res,
  output logic                             o_to_file,
  output logic                             o_to_acc,
  output logic                             o_c,
  output logic                             o_dc,
  output logic                             o_z,
  output logic                             o_skip
);
  import abe_pkg::*;

  logic [DATA_W-1:0] lit;
  logic [2:0]        bsel;
  logic [DATA_W-1:0] bmask;
  logic [DATA_W:0]   sum_lit;
  logic [DATA_W:0]   sum_file;
  logic [4:0]        nib_lit;
  logic [4:0]        nib_file;
  logic              dest_f;

  // Operand fields and both adders
  assign lit      = i_instr[LIT_LSB +: DATA_W];
  assign bsel     = i_instr[BIT_LSB +: 3];
  assign bmask    = 8'h01 << bsel;
  assign dest_f   = i_instr[DEST_POS];
  assign sum_lit  = {1'b0, i_acc} + {1'b0, lit};
  assign sum_file = {1'b0, i_acc} + {1'b0, i_oper};
  assign nib_lit  = {1'b0, i_acc[3:0]} + {1'b0, lit[3:0]};
  assign nib_file = {1'b0, i_acc[3:0]} + {1'b0, i_oper[3:0]};

  // Opcode decode; anything unknown falls through as a no-op
  always_comb begin
    o_res     = i_oper;
    o_to_file = 1'b0;
    o_to_acc  = 1'b0;
    o_c       = i_c;
    o_dc      = i_dc;
    o_z       = i_z;
    o_skip    = 1'b0;
    if (i_instr[13:9] == OPC_ADD_LIT) begin
      o_res    = sum_lit[7:0]; // RULE4
      o_to_acc = 1'b1;
      o_c      = sum_lit[8];   // RULE12
      o_dc     = nib_lit[4];   // RULE12
      o_z      = (sum_lit[7:0] == 8'h00);
    end else if (i_instr[13:8] == OPC_AND_LIT) begin
      o_res    = i_acc & lit;  // RULE8
      o_to_acc = 1'b1;
      o_z      = ((i_acc & lit) == 8'h00); // RULE12
    end else if (i_instr[13:8] == OPC_ADD_FILE) begin
      o_res     = sum_file[7:0]; // RULE7
      o_to_file = dest_f;
      o_to_acc  = !dest_f;
      o_c       = sum_file[8];
      o_dc      = nib_file[4];
      o_z       = (sum_file[7:0] == 8'h00);
    end else if (i_instr[13:8] == OPC_AND_FILE) begin
      o_res     = i_acc & i_oper; // RULE9
      o_to_file = dest_f;
      o_to_acc  = !dest_f;
      o_z       = ((i_acc & i_oper) == 8'h00);
    end else if (i_instr[13:10] == OPC_BIT_CLR) begin
      o_res     = i_oper & ~bmask; // RULE5
      o_to_file = 1'b1;
    end else if (i_instr[13:10] == OPC_BIT_SET) begin
      o_res     = i_oper | bmask; // RULE6
      o_to_file = 1'b1;
    end else if (i_instr[13:10] == OPC_TEST_CLR) begin
      o_skip = !i_oper[bsel]; // RULE10
    end else if (i_instr[13:10] == OPC_TEST_SET) begin
      o_skip = i_oper[bsel]; // RULE11
    end
  end
endmodule
`default_nettype wire

// ===== logic/abe_exec.sv
// Execute stage for add, AND and bit instructions with file and flag update
`timescale 1ns/1ns
`default_nettype none
module abe_exec (
  input  wire logic                       I_CLK,
  input  wire logic                       I_RST,
  input  wire logic                       I_INSTR_VALID,
  input  wire logic [abe_pkg::INSTR_W-1:0] I_INSTR,
  input  wire logic [abe_pkg::DATA_W-1:0]  I_FILE_RDATA,
  input  wire logic [abe_pkg::DATA_W-1:0]  I_PORT_PINS,
  input  wire logic                       I_PRESCALER_ON_TIMER0,
  output logic                            O_READY,
  output logic      [abe_pkg::ADDR_W-1:0]  O_FILE_ADDR,
  output logic                            O_FILE_RD,
  output logic                            O_FILE_WE,
  output logic      [abe_pkg::DATA_W-1:0]  O_FILE_WDATA,
  output logic      [abe_pkg::DATA_W-1:0]  O_ACC,
  output logic                            O_CARRY,
  output logic                            O_DIGIT_CARRY,
  output logic                            O_ZERO,
  output logic                            O_PRESCALER_CLR,
  output logic                            O_DONE,
  output logic                            O_SKIP_NEXT,
  output logic                            O_NOP_CYCLE
);
  import abe_pkg::*;

  abe_state_t          state_q;
  logic [INSTR_W-1:0]  instr_q;
  logic [ADDR_W-1:0]   addr_q;
  logic                rd_q;
  logic                we_q;
  logic [DATA_W-1:0]   wdata_q;
  logic [DATA_W-1:0]   acc_q;
  logic                c_q;
  logic                dc_q;
  logic                z_q;
  logic                clr_q;
  logic                done_q;
  logic                skip_q;
  logic                nop_q;
  logic                ready_q;
  logic [DATA_W-1:0]   pin_s1_q;
  logic [DATA_W-1:0]   pin_s2_q;
  logic [DATA_W-1:0]   pin_s3_q;
  logic [DATA_W-1:0]   pins_q;
  logic [DATA_W-1:0]   operand;
  logic [DATA_W-1:0]   alu_res;
  logic                alu_to_file;
  logic                alu_to_acc;
  logic                alu_c;
  logic                alu_dc;
  logic                alu_z;
  logic                alu_skip;
  logic                in_exec;
  logic                pc_write;
  logic                two_cycle;
  logic                accept;

  // Pin levels cross in through three stages; a bit moves only when stages two and three agree
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      pin_s3_q <= 8'h00;
      pins_q   <= 8'h00;
    end else begin
      pin_s1_q <= I_PORT_PINS;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < DATA_W; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pins_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // Port reads take the pin levels so input pins are not rewritten from the latch
  assign operand = (addr_q == PORT_ADDR) ? pins_q : I_FILE_RDATA; // RULE1

  abe_alu u_alu (
    .i_instr   (instr_q),
    .i_acc     (acc_q),
    .i_oper    (operand),
    .i_c       (c_q),
    .i_dc      (dc_q),
    .i_z       (z_q),
    .o_res     (alu_res),
    .o_to_file (alu_to_file),
    .o_to_acc  (alu_to_acc),
    .o_c       (alu_c),
    .o_dc      (alu_dc),
    .o_z       (alu_z),
    .o_skip    (alu_skip)
  );

  // Writing the low program counter byte changes flow just like a taken skip
  assign accept    = ready_q && I_INSTR_VALID;
  assign in_exec   = (state_q == ST_EXEC);
  assign pc_write  = alu_to_file && (addr_q == PC_LOW_ADDR);
  assign two_cycle = alu_skip || pc_write; // RULE3

  // Sequencer: one execute cycle, plus a no-op cycle when flow changes
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b1;
      nop_q   <= 1'b0;
    end else begin
      nop_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_EXEC;
            ready_q <= 1'b0;
          end
        end
        ST_EXEC: begin
          if (two_cycle) begin
            state_q <= ST_NOP; // RULE3
            nop_q   <= 1'b1;
          end else begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
          end
        end
        ST_NOP: begin
          state_q <= ST_IDLE;
          ready_q <= 1'b1;
        end
        default: begin
          state_q <= ST_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // Instruction capture and file read request; literal forms skip the read
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      instr_q <= 14'h0000;
      addr_q  <= 7'h00;
      rd_q    <= 1'b0;
    end else if (accept) begin
      instr_q <= I_INSTR;
      addr_q  <= I_INSTR[F_LSB +: ADDR_W];
      rd_q    <= (I_INSTR[13:12] != LIT_CLASS);
    end else if (in_exec) begin
      rd_q <= 1'b0;
    end
  end

  // Result write-back to file or accumulator, and flags
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      we_q    <= 1'b0;
      wdata_q <= 8'h00;
      acc_q   <= ACC_RST;
      c_q     <= FLAG_RST;
      dc_q    <= FLAG_RST;
      z_q     <= FLAG_RST;
    end else begin
      we_q <= in_exec && alu_to_file;
      if (in_exec) begin
        wdata_q <= alu_res;
        c_q     <= alu_c;  // RULE12
        dc_q    <= alu_dc;
        z_q     <= alu_z;
        if (alu_to_acc) begin
          acc_q <= alu_res;
        end
      end
    end
  end

  // Completion, skip and prescaler pulses, one cycle each
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      done_q <= 1'b0;
      skip_q <= 1'b0;
      clr_q  <= 1'b0;
    end else begin
      done_q <= in_exec;
      skip_q <= in_exec && two_cycle; // RULE10 RULE11
      clr_q  <= in_exec && alu_to_file && (addr_q == TIMER0_COUNT_ADDR)
                && I_PRESCALER_ON_TIMER0; // RULE2
    end
  end

  assign O_READY         = ready_q;
  assign O_FILE_ADDR     = addr_q;
  assign O_FILE_RD       = rd_q;
  assign O_FILE_WE       = we_q;
  assign O_FILE_WDATA    = wdata_q;
  assign O_ACC           = acc_q;
  assign O_CARRY         = c_q;
  assign O_DIGIT_CARRY   = dc_q;
  assign O_ZERO          = z_q;
  assign O_PRESCALER_CLR = clr_q;
  assign O_DONE          = done_q;
  assign O_SKIP_NEXT     = skip_q;
  assign O_NOP_CYCLE     = nop_q;

  // Checks on the execute behaviour
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  logic [2:0] bsel;
  logic       op_add_lit;
  logic       op_and_lit;
  logic       op_add_file;
  logic       op_and_file;
  logic       op_bclr;
  logic       op_bset;
  logic       op_tclr;
  logic       op_tset;
  assign bsel        = instr_q[BIT_LSB +: 3];
  assign op_add_lit  = in_exec && (instr_q[13:9] == OPC_ADD_LIT);
  assign op_and_lit  = in_exec && (instr_q[13:8] == OPC_AND_LIT);
  assign op_add_file = in_exec && (instr_q[13:8] == OPC_ADD_FILE);
  assign op_and_file = in_exec && (instr_q[13:8] == OPC_AND_FILE);
  assign op_bclr     = in_exec && (instr_q[13:10] == OPC_BIT_CLR);
  assign op_bset     = in_exec && (instr_q[13:10] == OPC_BIT_SET);
  assign op_tclr     = in_exec && (instr_q[13:10] == OPC_TEST_CLR);
  assign op_tset     = in_exec && (instr_q[13:10] == OPC_TEST_SET);

  sequence s_nop_then_ready;
    O_NOP_CYCLE && !O_READY ##1 O_READY;
  endsequence

  property p_port_pins;
    op_bset && (addr_q == PORT_ADDR) |=> O_FILE_WDATA == ($past(pins_q) | (8'h01 << $past(bsel)));
  endproperty
  a_port_pins: assert property (p_port_pins) else $error("port source not pins"); // RULE1

  property p_presc_clr;
    in_exec && alu_to_file && addr_q == TIMER0_COUNT_ADDR && I_PRESCALER_ON_TIMER0
      |=> O_PRESCALER_CLR && O_FILE_WE ##1 !O_PRESCALER_CLR;
  endproperty
  a_presc_clr: assert property (p_presc_clr) else $error("prescaler not cleared"); // RULE2

  property p_two_cycle;
    O_SKIP_NEXT |-> s_nop_then_ready;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("skip lacks no-op cycle"); // RULE3

  property p_add_lit;
    op_add_lit |=> {O_CARRY, O_ACC} == {1'b0, $past(acc_q)} + {1'b0, $past(instr_q[7:0])}
      && O_ZERO == (O_ACC == 8'h00);
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("add literal wrong"); // RULE4

  property p_bclr;
    op_bclr |=> O_FILE_WE && !O_FILE_WDATA[$past(bsel)] && $stable({c_q, dc_q, z_q});
  endproperty
  a_bclr: assert property (p_bclr) else $error("bit clear wrong"); // RULE5

  property p_bset;
    op_bset |=> O_FILE_WE && O_FILE_WDATA[$past(bsel)] && $stable({c_q, dc_q, z_q});
  endproperty
  a_bset: assert property (p_bset) else $error("bit set wrong"); // RULE6

  property p_add_file;
    op_add_file && instr_q[DEST_POS] |=> O_FILE_WE && $stable(acc_q)
      && {O_CARRY, O_FILE_WDATA} == {1'b0, $past(acc_q)} + {1'b0, $past(operand)};
  endproperty
  a_add_file: assert property (p_add_file) else $error("add file wrong"); // RULE7 RULE12

  property p_and_lit;
    op_and_lit |=> $stable({c_q, dc_q}) && O_ZERO == (O_ACC == 8'h00)
      && O_ACC == ($past(acc_q) & $past(instr_q[7:0]));
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("and literal flags wrong"); // RULE8

  property p_and_file;
    op_and_file && !instr_q[DEST_POS] |=> !O_FILE_WE && $stable({c_q, dc_q})
      && O_ACC == ($past(acc_q) & $past(operand));
  endproperty
  a_and_file: assert property (p_and_file) else $error("and file wrong"); // RULE9

  property p_tclr;
    op_tclr && !operand[bsel] |=> O_SKIP_NEXT ##0 s_nop_then_ready;
  endproperty
  a_tclr: assert property (p_tclr) else $error("skip if clear missed"); // RULE10

  property p_tset;
    op_tset |=> O_SKIP_NEXT == $past(operand[bsel]) && !O_FILE_WE;
  endproperty
  a_tset: assert property (p_tset) else $error("skip if set wrong"); // RULE11
endmodule
`default_nettype wire

// ===== logic/abe_pkg.sv
// Constants, field layout and state type for the add/and/bit execute block
// Contract
// (RULE1) Read-modify-write of an I/O port takes its source from the pin levels.
// (RULE2) A result written to timer0 count clears the prescaler if assigned to timer0.
// (RULE3) Program counter change or true test costs two cycles, the second a no-op.
// (RULE4) Add literal: accumulator plus 8-bit literal into accumulator; carry, digit carry, zero.
// (RULE5) Bit clear forces bit b of file f to zero; flags untouched.
// (RULE6) Bit set forces bit b of file f to one; flags untouched.
// (RULE7) Add file: accumulator plus f to accumulator (d=0) or f (d=1); three flags.
// (RULE8) AND literal: accumulator AND literal into accumulator; only zero flag changes.
// (RULE9) AND file: accumulator AND f steered by d; only zero flag changes.
// (RULE10) Test-skip-if-clear: bit zero discards the next instruction, two cycles.
// (RULE11) Test-skip-if-set: bit one discards the next instruction, two cycles.
// (RULE12) Zero when result is zero; carry from bit 7; digit carry from bit 3.
package abe_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;

  // Field positions inside the instruction word
  localparam int F_LSB   = 0;
  localparam int DEST_POS = 7;
  localparam int BIT_LSB = 7;
  localparam int LIT_LSB = 0;

  // Opcode prefixes
  localparam logic [4:0] OPC_ADD_LIT  = 5'h1f; // bits 13:9
  localparam logic [5:0] OPC_AND_LIT  = 6'h39; // bits 13:8
  localparam logic [5:0] OPC_ADD_FILE = 6'h07; // bits 13:8
  localparam logic [5:0] OPC_AND_FILE = 6'h05; // bits 13:8
  localparam logic [3:0] OPC_BIT_CLR  = 4'h4;  // bits 13:10
  localparam logic [3:0] OPC_BIT_SET  = 4'h5;
  localparam logic [3:0] OPC_TEST_CLR = 4'h6;
  localparam logic [3:0] OPC_TEST_SET = 4'h7;
  localparam logic [1:0] LIT_CLASS    = 2'h3;  // bits 13:12, no file read

  // File addresses with side effects
  localparam logic [6:0] TIMER0_COUNT_ADDR = 7'h01;
  localparam logic [6:0] PC_LOW_ADDR       = 7'h02;
  localparam logic [6:0] PORT_ADDR         = 7'h05;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic       FLAG_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_NOP  = 3'b100
  } abe_state_t;
endpackage
